// >>> hdl/ssem_pkg.sv
// constants for the management-interrupt source enable block
package ssem_pkg;

  // widths
  localparam int unsigned SSEM_AW   = 8;
  localparam int unsigned SSEM_DW   = 8;
  localparam int unsigned SSEM_NSRC = 32;

  // latched event status registers, write one to clear
  localparam logic [7:0] SSEM_OFF_STS_P2     = 8'h12;
  localparam logic [7:0] SSEM_OFF_STS_P3_FAN = 8'h13;
  localparam logic [7:0] SSEM_OFF_STS_P5     = 8'h14;
  localparam logic [7:0] SSEM_OFF_STS_P1     = 8'h15;

  // per-source enable registers
  localparam logic [7:0] SSEM_OFF_EN_P2      = 8'h18;
  localparam logic [7:0] SSEM_OFF_EN_P3_FAN  = 8'h19;
  localparam logic [7:0] SSEM_OFF_EN_P5      = 8'h1a;
  localparam logic [7:0] SSEM_OFF_EN_P1      = 8'h1b;

  // routing control and block interrupt registers
  localparam logic [7:0] SSEM_OFF_ROUTE      = 8'h20;
  localparam logic [7:0] SSEM_OFF_ISTS       = 8'h21;
  localparam logic [7:0] SSEM_OFF_IMASK      = 8'h22;

  // values after reset
  localparam logic [31:0] SSEM_RST_EN    = 32'h0000_0000;
  localparam logic [31:0] SSEM_RST_STS   = 32'h0000_0000;
  localparam logic [1:0]  SSEM_RST_ROUTE = 2'h0;
  localparam logic [1:0]  SSEM_RST_ISTS  = 2'h0;
  localparam logic [1:0]  SSEM_RST_IMASK = 2'h0;
  localparam logic [7:0]  SSEM_RST_RDATA = 8'h00;

  // implemented source bits; bit 31 (port-1 line 7) is absent
  localparam logic [31:0] SSEM_SRC_IMPL  = 32'h7fff_ffff;

  // field positions in the source vector
  localparam int unsigned SSEM_BIT_P6_L0 = 3;
  localparam int unsigned SSEM_BIT_P4_L1 = 12;
  localparam int unsigned SSEM_BIT_FAN   = 13;
  localparam int unsigned SSEM_BIT_P4_L3 = 14;
  localparam int unsigned SSEM_BIT_P6_L1 = 15;

  // field positions in the route and interrupt registers
  localparam int unsigned SSEM_ROUTE_MASTER = 0;
  localparam int unsigned SSEM_ROUTE_SERIAL = 1;
  localparam int unsigned SSEM_ISTS_GRP     = 0;
  localparam int unsigned SSEM_ISTS_NEW     = 1;

  // synchroniser depth in clock cycles
  localparam int unsigned SSEM_SYNC_STAGES = 2;

endpackage : ssem_pkg

// >>> hdl/ssem_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module ssem_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // ssem_sync

// >>> hdl/ssem_top.sv
// management-interrupt source latch, per-source enable masking and group routing
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module ssem_top
  import ssem_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // event source pins
  input  wire logic [6:0]   gpio_p1_in,
  input  wire logic [7:0]   gpio_p2_in,
  input  wire logic [3:0]   gpio_p3_in,
  input  wire logic         gpio_p4_l1,
  input  wire logic         gpio_p4_l3,
  input  wire logic [7:0]   gpio_p5_in,
  input  wire logic         gpio_p6_l0,
  input  wire logic         gpio_p6_l1,
  input  wire logic         fan_speed_pulse_in,
  // management-interrupt outputs
  output logic [31:0]       mgmt_irq_status_bus,
  output logic              group_mgmt_irq_out_n,
  output logic              mgmt_irq_pin_n_o,
  output logic              mgmt_irq_pin_n_oe,
  output logic              serial_irq_req,
  // block interrupt
  output logic              irq
);

  // raw source vector, laid out as the enable registers
  logic [31:0] src_raw;
  logic [31:0] src_sync;

  // source state
  logic [31:0] src_prev_ff;
  logic [31:0] nxt_src_prev_ff;
  logic [31:0] sts_ff;
  logic [31:0] nxt_sts_ff;
  logic [31:0] en_ff;
  logic [31:0] nxt_en_ff;
  logic [31:0] sts_clr;
  logic [31:0] evt_rise;

  // routing and block interrupt state
  logic [1:0]  route_ff;
  logic [1:0]  nxt_route_ff;
  logic [1:0]  ists_ff;
  logic [1:0]  nxt_ists_ff;
  logic [1:0]  imask_ff;
  logic [1:0]  nxt_imask_ff;
  logic [1:0]  ists_evt;

  // output registers
  logic [31:0] stbus_ff;
  logic [31:0] nxt_stbus_ff;
  logic        grp_ff;
  logic        nxt_grp_ff;
  logic        pin_n_ff;
  logic        nxt_pin_n_ff;
  logic        pin_oe_ff;
  logic        nxt_pin_oe_ff;
  logic        serirq_ff;
  logic        nxt_serirq_ff;
  logic        irq_ff;
  logic        nxt_irq_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata_ff;
  logic        grp_n_ff;
  logic        nxt_grp_n_ff;

  // register port hits for the one-field registers
  logic        hit_route_wr;
  logic        hit_imask_wr;
  logic        hit_ists_rd;

  // full address compare, so no alias can move the routing or clear the block status
  assign hit_route_wr = reg_wr && (reg_addr == SSEM_OFF_ROUTE);
  assign hit_imask_wr = reg_wr && (reg_addr == SSEM_OFF_IMASK);
  assign hit_ists_rd  = reg_rd && (reg_addr == SSEM_OFF_ISTS);

  // place each pin at its enable bit position
  always_comb begin
    src_raw                 = '0;
    src_raw[7:0]            = gpio_p2_in;
    // port-2 line 3 has no event input; its slot carries port-6 line 0
    src_raw[SSEM_BIT_P6_L0] = gpio_p6_l0;
    src_raw[11:8]           = gpio_p3_in;
    src_raw[SSEM_BIT_P4_L1] = gpio_p4_l1;
    src_raw[SSEM_BIT_FAN]   = fan_speed_pulse_in;
    src_raw[SSEM_BIT_P4_L3] = gpio_p4_l3;
    src_raw[SSEM_BIT_P6_L1] = gpio_p6_l1;
    src_raw[23:16]          = gpio_p5_in;
    src_raw[30:24]          = gpio_p1_in;
  end

  // pins are asynchronous to clk
  ssem_sync #(
    .WIDTH (SSEM_NSRC)
  ) u_src_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (src_raw),
    .sync_out (src_sync)
  );

  // a low-to-high transition is one event; the fan pulse counts the same way
  assign evt_rise = src_sync & ~src_prev_ff & SSEM_SRC_IMPL;

  // write-one-to-clear decode of the status registers
  always_comb begin
    sts_clr = '0;
    if (reg_wr) begin
      case (reg_addr)
        SSEM_OFF_STS_P2:     sts_clr[7:0]   = reg_wdata;
        SSEM_OFF_STS_P3_FAN: sts_clr[15:8]  = reg_wdata;
        SSEM_OFF_STS_P5:     sts_clr[23:16] = reg_wdata;
        SSEM_OFF_STS_P1:     sts_clr[31:24] = reg_wdata;
        default:             sts_clr        = '0;
      endcase
    end
  end

  // next source state; a new event beats a clear in the same cycle
  always_comb begin
    nxt_src_prev_ff = src_sync;
    nxt_sts_ff      = ((sts_ff & ~sts_clr) | evt_rise) & SSEM_SRC_IMPL;
  end

  // status latches even while disabled, so enabling later still reports the event
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_prev_ff <= '0;
      sts_ff      <= SSEM_RST_STS;
    end else begin
      src_prev_ff <= nxt_src_prev_ff;
      sts_ff      <= nxt_sts_ff;
    end
  end

  // enable registers; absent port-1 line 7 is forced to zero so it gates nothing
  always_comb begin
    nxt_en_ff = en_ff;
    if (reg_wr) begin
      case (reg_addr)
        SSEM_OFF_EN_P2:     nxt_en_ff[7:0]   = reg_wdata;
        SSEM_OFF_EN_P3_FAN: nxt_en_ff[15:8]  = reg_wdata;
        SSEM_OFF_EN_P5:     nxt_en_ff[23:16] = reg_wdata;
        SSEM_OFF_EN_P1:     nxt_en_ff[31:24] = reg_wdata & SSEM_SRC_IMPL[31:24];
        default:            nxt_en_ff        = en_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= SSEM_RST_EN;
    end else begin
      en_ff <= nxt_en_ff;
    end
  end

  // masking of the status bus and the group output
  always_comb begin
    nxt_stbus_ff = sts_ff & en_ff;
    nxt_grp_ff   = |(sts_ff & en_ff);
    nxt_grp_n_ff = !nxt_grp_ff;
  end

  // group output has its own inverted flop, so no gate sits after it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stbus_ff <= '0;
      grp_ff   <= 1'b0;
      grp_n_ff <= 1'b1;
    end else begin
      stbus_ff <= nxt_stbus_ff;
      grp_ff   <= nxt_grp_ff;
      grp_n_ff <= nxt_grp_n_ff;
    end
  end

  // routing control: bit 0 master enable, bit 1 picks the serial stream over the pin
  always_comb begin
    nxt_route_ff = route_ff;
    if (hit_route_wr) begin
      nxt_route_ff = reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      route_ff <= SSEM_RST_ROUTE;
    end else begin
      route_ff <= nxt_route_ff;
    end
  end

  // pin and serial request, one edge behind the group output; low pin means asserted
  always_comb begin
    nxt_pin_oe_ff = route_ff[SSEM_ROUTE_MASTER] && !route_ff[SSEM_ROUTE_SERIAL];
    nxt_pin_n_ff  = !(nxt_pin_oe_ff && grp_ff);
    nxt_serirq_ff = route_ff[SSEM_ROUTE_MASTER] && route_ff[SSEM_ROUTE_SERIAL] && grp_ff;
  end

  // pin driven push-pull only while routed, so an idle pin rests high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe_ff <= 1'b0;
      pin_n_ff  <= 1'b1;
      serirq_ff <= 1'b0;
    end else begin
      pin_oe_ff <= nxt_pin_oe_ff;
      pin_n_ff  <= nxt_pin_n_ff;
      serirq_ff <= nxt_serirq_ff;
    end
  end

  // block interrupt events: group rising, any new source event
  assign ists_evt[SSEM_ISTS_GRP] = nxt_grp_ff && !grp_ff;
  assign ists_evt[SSEM_ISTS_NEW] = |evt_rise;

  // sticky status cleared by a read; an event in the read cycle survives
  always_comb begin
    nxt_ists_ff  = ists_ff;
    nxt_imask_ff = imask_ff;
    if (hit_ists_rd) begin
      nxt_ists_ff = '0;
    end
    nxt_ists_ff = nxt_ists_ff | ists_evt;
    if (hit_imask_wr) begin
      nxt_imask_ff = reg_wdata[1:0];
    end
    nxt_irq_ff = |(nxt_ists_ff & nxt_imask_ff);
  end

  // irq registered from the next values, so it tracks status without extra lag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ists_ff  <= SSEM_RST_ISTS;
      imask_ff <= SSEM_RST_IMASK;
      irq_ff   <= 1'b0;
    end else begin
      ists_ff  <= nxt_ists_ff;
      imask_ff <= nxt_imask_ff;
      irq_ff   <= nxt_irq_ff;
    end
  end

  // read mux; data stand one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata_ff = SSEM_RST_RDATA;
    if (reg_rd) begin
      case (reg_addr)
        SSEM_OFF_STS_P2:     nxt_rdata_ff = sts_ff[7:0];
        SSEM_OFF_STS_P3_FAN: nxt_rdata_ff = sts_ff[15:8];
        SSEM_OFF_STS_P5:     nxt_rdata_ff = sts_ff[23:16];
        SSEM_OFF_STS_P1:     nxt_rdata_ff = sts_ff[31:24];
        SSEM_OFF_EN_P2:      nxt_rdata_ff = en_ff[7:0];
        SSEM_OFF_EN_P3_FAN:  nxt_rdata_ff = en_ff[15:8];
        SSEM_OFF_EN_P5:      nxt_rdata_ff = en_ff[23:16];
        SSEM_OFF_EN_P1:      nxt_rdata_ff = en_ff[31:24];
        SSEM_OFF_ROUTE:      nxt_rdata_ff = {6'h00, route_ff};
        SSEM_OFF_ISTS:       nxt_rdata_ff = {6'h00, ists_ff};
        SSEM_OFF_IMASK:      nxt_rdata_ff = {6'h00, imask_ff};
        default:             nxt_rdata_ff = SSEM_RST_RDATA; // unmapped reads zero
      endcase
    end
  end

  // registered so read data stand exactly in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= SSEM_RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata_ff;
    end
  end

  // all outputs straight from flops
  assign reg_rdata            = rdata_ff;
  assign mgmt_irq_status_bus  = stbus_ff;
  assign group_mgmt_irq_out_n = grp_n_ff;
  assign mgmt_irq_pin_n_o     = pin_n_ff;
  assign mgmt_irq_pin_n_oe    = pin_oe_ff;
  assign serial_irq_req       = serirq_ff;
  assign irq                  = irq_ff;

endmodule // ssem_top

// >>> test/ssem_top_properties.sv
// port assertions for the management-interrupt source enable block
`timescale 1ns/10ps
module ssem_chk
  import ssem_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // sources and outputs
  input wire logic [7:0]  gpio_p2_in,
  input wire logic [31:0] mgmt_irq_status_bus,
  input wire logic        group_mgmt_irq_out_n,
  input wire logic        mgmt_irq_pin_n_o,
  input wire logic        mgmt_irq_pin_n_oe,
  input wire logic        serial_irq_req
);
  logic [31:0] en_ff;
  logic [31:0] nxt_en;
  logic [7:0]  en_byte;
  logic        clr0;
  // shadow of the enable bytes, so masking can be judged from ports alone
  always_comb begin
    nxt_en = en_ff;
    if (reg_wr && reg_addr[7:2] == 6'h06) nxt_en[reg_addr[1:0]*8 +: 8] = reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) en_ff <= SSEM_RST_EN;
    else en_ff <= nxt_en;
  end
  // absent port-1 line 7 reads back as zero
  assign en_byte = 8'((en_ff & SSEM_SRC_IMPL) >> {reg_addr[1:0], 3'h0});
  assign clr0    = reg_wr && reg_addr == SSEM_OFF_STS_P2 && reg_wdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_bus_masked: assert property ((mgmt_irq_status_bus & ~$past(en_ff)) == 32'h0)
    else $error("status bus bit set while disabled");
  a_enabled_event: assert property ($rose(gpio_p2_in[0]) && en_ff[0] |-> ##4 mgmt_irq_status_bus[0])
    else $error("enabled event missing on status bus");
  a_status_sticky: assert property ($fell(mgmt_irq_status_bus[0]) |-> $past(clr0, 2) || !$past(en_ff[0]))
    else $error("status bus bit dropped without clear");
  a_group_or: assert property (group_mgmt_irq_out_n == !(|mgmt_irq_status_bus))
    else $error("group output not OR of status bus");
  a_pin_follows: assert property (mgmt_irq_pin_n_oe && $past(mgmt_irq_pin_n_oe)
    |-> mgmt_irq_pin_n_o == $past(group_mgmt_irq_out_n))
    else $error("pin does not follow group output");
  a_serial_follows: assert property (serial_irq_req |-> !$past(group_mgmt_irq_out_n))
    else $error("serial request without group output");
  a_read_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_en_readback: assert property ($past(reg_rd && reg_addr[7:2] == 6'h06) |-> reg_rdata == $past(en_byte))
    else $error("enable readback mismatch");
  c_group: cover property (!group_mgmt_irq_out_n);
  c_pin: cover property (mgmt_irq_pin_n_oe && !mgmt_irq_pin_n_o);
  c_serial: cover property (serial_irq_req);
endmodule // ssem_chk

bind ssem_top ssem_chk ssem_chk_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .gpio_p2_in, .mgmt_irq_status_bus, .group_mgmt_irq_out_n, .mgmt_irq_pin_n_o, .mgmt_irq_pin_n_oe,
  .serial_irq_req);

// >>> test/ssem_host_model.sv
// chipset side: pin with pull-up and serial request receiver
`timescale 1ns/10ps
module ssem_host_model (
  // from the block
  input wire logic pin_n_o,
  input wire logic pin_n_oe,
  input wire logic serial_req,
  // seen by the chipset
  output logic     pin_level,
  output logic     mgmt_active
);
  // undriven pin floats to the pull-up, never the last driven value
  assign pin_level   = pin_n_oe ? pin_n_o : 1'b1;
  assign mgmt_active = !pin_level || serial_req;
endmodule // ssem_host_model

// >>> test/ssem_tb_top.sv
// self-checking bench for the source enable block
`timescale 1ns/10ps
module ssem_tb_top;
  import ssem_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd_s = 1'b0;
  logic [7:0]  a = 8'h00, wd = 8'h00, rdata;
  logic [31:0] src = 32'h0, bus;
  logic        group_n, pin_o, pin_oe, ser, irq, pin_lvl, active;
  logic [7:0]  en_off [4] = '{SSEM_OFF_EN_P2, SSEM_OFF_EN_P3_FAN, SSEM_OFF_EN_P5, SSEM_OFF_EN_P1};
  logic [7:0]  sts_off [4] = '{SSEM_OFF_STS_P2, SSEM_OFF_STS_P3_FAN, SSEM_OFF_STS_P5, SSEM_OFF_STS_P1};
  int          n_fail = 0, n_compared = 0, cyc = 0;
  always #12.5 clk = ~clk;
  ssem_top ssem_top_inst (.clk, .rst_b, .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd_s),
    .reg_rdata(rdata), .gpio_p1_in(src[30:24]), .gpio_p2_in(src[7:0]), .gpio_p3_in(src[11:8]),
    .gpio_p4_l1(src[12]), .gpio_p4_l3(src[14]), .gpio_p5_in(src[23:16]), .gpio_p6_l0(src[3]),
    .gpio_p6_l1(src[15]), .fan_speed_pulse_in(src[13]), .mgmt_irq_status_bus(bus),
    .group_mgmt_irq_out_n(group_n), .mgmt_irq_pin_n_o(pin_o), .mgmt_irq_pin_n_oe(pin_oe),
    .serial_irq_req(ser), .irq);
  ssem_host_model ssem_host_model_inst (.pin_n_o(pin_o), .pin_n_oe(pin_oe), .serial_req(ser),
    .pin_level(pin_lvl), .mgmt_active(active));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("reg_rdata", e, rdata);
  endtask
  task automatic t_reset();
    foreach (en_off[i]) rreg(en_off[i], 8'h00);
    rreg(8'h30, 8'h00);
    chk("pin_level", 1, pin_lvl);
    $display("test reset done");
  endtask
  task automatic t_regs();
    foreach (en_off[i]) begin
      wreg(en_off[i], 8'hff);
      rreg(en_off[i], (i == 3) ? 8'h7f : 8'hff);
      wreg(en_off[i], 8'h00);
    end
    wreg(8'h30, 8'h5a);
    rreg(8'h30, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_masked();
    @(posedge clk) src <= 32'h7fff_ffff;
    w(8);
    chk("status_bus", 0, bus);
    chk("group_n", 1, group_n);
    foreach (sts_off[i]) rreg(sts_off[i], (i == 3) ? 8'h7f : 8'hff);
    foreach (sts_off[i]) wreg(sts_off[i], 8'hff);
    rreg(sts_off[0], 8'h00);
    $display("test masked done");
  endtask
  task automatic t_enabled();
    @(posedge clk) src <= 32'h0;
    foreach (en_off[i]) wreg(en_off[i], 8'hff);
    @(posedge clk) src <= 32'h7fff_ffff;
    w(6);
    chk("status_bus", 32'h7fff_ffff, bus);
    chk("group_n", 0, group_n);
    @(posedge clk) src <= 32'h0;
    w(6);
    chk("status_bus", 32'h7fff_ffff, bus);
    $display("test enabled done");
  endtask
  task automatic t_route();
    wreg(SSEM_OFF_ROUTE, 8'h01);
    w(3);
    chk("pin_level", 0, pin_lvl);
    chk("serial", 0, ser);
    wreg(SSEM_OFF_ROUTE, 8'h03);
    w(3);
    chk("pin_oe", 0, pin_oe);
    chk("serial", 1, ser);
    wreg(SSEM_OFF_ROUTE, 8'h00);
    w(3);
    chk("active", 0, active);
    $display("test route done");
  endtask
  task automatic t_clear();
    wreg(SSEM_OFF_EN_P2, 8'h00);
    w(3);
    chk("status_bus", 32'h7fff_ff00, bus);
    foreach (sts_off[i]) wreg(sts_off[i], 8'hff);
    w(3);
    chk("group_n", 1, group_n);
    chk("irq", 0, irq);
    $display("test clear done");
  endtask
  task automatic t_irq();
    rreg(SSEM_OFF_ISTS, 8'h03);
    wreg(SSEM_OFF_IMASK, 8'h02);
    @(posedge clk) src[16] <= 1'b1;
    w(6);
    chk("irq", 1, irq);
    chk("status_bus", 32'h0001_0000, bus);
    rreg(SSEM_OFF_ISTS, 8'h03);
    w(2);
    chk("irq", 0, irq);
    @(posedge clk) src[13] <= 1'b1;
    w(6);
    chk("status_bus", 32'h0001_2000, bus);
    $display("test irq done");
  endtask
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 160 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_masked();
    t_enabled();
    t_route();
    t_clear();
    t_irq();
    test_done();
  end
endmodule // ssem_tb_top
